//--- design/sfbf_defines.svh
/*
 * Constants of the serial flash front end: array geometry, opcodes, identity
 * values, timing and reset values.
 * Assumes it is included by bare name from the design module and the testbench.
 */
`ifndef SFBF_DEFINES_SVH
`define SFBF_DEFINES_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define SFBF_PAGES          4096
`define SFBF_PAGE_MAX       264
`define SFBF_LAST_264       9'h107
`define SFBF_LAST_256       9'h0FF
`define SFBF_SEC_USER       64
`define SFBF_PAGE264_RST    1'b1

// ----------------------------------------------------------------------------
// Opcodes; bit 0 selects buffer 1 or 2 where a buffer is involved
// ----------------------------------------------------------------------------
`define SFBF_OP_BUF_WR      7'h08
`define SFBF_OP_BUF_PROG    7'h10
`define SFBF_OP_BUF_RD      7'h28
`define SFBF_OP_PAGE_ERASE  8'h30
`define SFBF_OP_PAGE_RD     8'h40
`define SFBF_OP_STATUS      8'h60
`define SFBF_OP_ID_RD       8'h70
`define SFBF_OP_SEC_RD      8'h80
`define SFBF_OP_SEC_PROG    8'h81
`define SFBF_OP_SIZE_256    8'h90
`define SFBF_OP_SIZE_264    8'h91

// ----------------------------------------------------------------------------
// Identity (values are arbitrary)
// ----------------------------------------------------------------------------
`define SFBF_MFR_ID         8'h5A
`define SFBF_DEV_ID         8'hC3
`define SFBF_UID_SEED       8'h3C

// ----------------------------------------------------------------------------
// Timing and pin reset value
// ----------------------------------------------------------------------------
`define SFBF_CLK_MHZ        10
`define SFBF_PROG_TIME_US   1000
`define SFBF_ERASE_TIME_US  1000
`define SFBF_PIN_RST        5'h19

`endif

//--- design/sfbf_pkg.sv
/*
 * Types shared by the serial flash front end.
 * Assumes sfbf_defines.svh is on the include path.
 */
package sfbf_pkg;
    // Self-timed engine states
    typedef enum logic [1:0] {
        BUSY_IDLE  = 2'b00,
        BUSY_COPY  = 2'b01,
        BUSY_ERASE = 2'b10,
        BUSY_WAIT  = 2'b11
    } sfbf_busy_type;
endpackage

//--- design/sfbf_frontend.sv
/*
 * Serial front end of a page-organised flash with two page buffers: select
 * framing, bit shifting on the serial clock edges, command decode, buffers,
 * main array, security area and the self-timed program and erase engine.
 * Assumes all pins come from outside the ref_clk domain and that the serial
 * clock is at most an eighth of ref_clk.
 */
// Operation
// - Deselected device ignores all serial input
// - Deselect floats output, enters standby
// - Select fall starts, rise ends operation
// - Self-timed work delays standby until done
// - Sample input on serial clock rise
// - Change output on serial clock fall
// - Modes 0 and 3 behave alike
// - Array is 4096 pages of 256/264
// - Two buffers, fill one while programming other
// - Program and erase timed internally
// - 128-byte security area, half fixed ID
// - Identification read returns maker, device codes
// - MSB first, opcode right after select
// - Reset pin low aborts, holds idle
// - Write-protect low discards program or erase
`timescale 1ns/1ps
`include "sfbf_defines.svh"

module sfbf_frontend #(
    parameter int PROG_CYCLES  = `SFBF_PROG_TIME_US * `SFBF_CLK_MHZ,
    parameter int ERASE_CYCLES = `SFBF_ERASE_TIME_US * `SFBF_CLK_MHZ
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic csN,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic wpN,
    input  wire logic rstN,
    output logic      soOut,
    output logic      soOe,
    output logic      standby,
    output logic      busy
);
    import sfbf_pkg::*;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [4:0] pinMeta_reg;
    logic [4:0] pinSync_reg;
    logic       sckPrev_reg;
    logic       csPrev_reg;

    // Two flops per pin: {rstN, wpN, si, sck, csN}
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pinMeta_reg <= `SFBF_PIN_RST;
            pinSync_reg <= `SFBF_PIN_RST;
            sckPrev_reg <= 1'b0;
            csPrev_reg  <= 1'b1;
        end else begin
            pinMeta_reg <= {rstN, wpN, si, sck, csN};
            pinSync_reg <= pinMeta_reg;
            sckPrev_reg <= pinSync_reg[1];
            csPrev_reg  <= pinSync_reg[0];
        end
    end

    wire csLow   = ~pinSync_reg[0];
    wire sckRise = pinSync_reg[1] & ~sckPrev_reg;
    wire sckFall = ~pinSync_reg[1] & sckPrev_reg;
    wire csFall  = csLow & csPrev_reg;
    wire csRise  = ~csLow & ~csPrev_reg;
    wire siS     = pinSync_reg[2];
    wire wpLow   = ~pinSync_reg[3];
    wire rstAll  = sys_rst | ~pinSync_reg[4];

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    logic [7:0] mainMem [0:`SFBF_PAGES*`SFBF_PAGE_MAX-1];
    logic [7:0] bufMem  [0:1][0:`SFBF_PAGE_MAX-1];
    logic [7:0] secUser [0:`SFBF_SEC_USER-1];

    // Physical stride is always 264 so both page sizes share one map
    function automatic logic [20:0] pageBase(input logic [11:0] page);
        pageBase = {1'b0, page, 8'h00} + {6'h00, page, 3'h0};
    endfunction

    // ------------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------------
    logic [2:0]    bitCnt_reg;
    logic [6:0]    rxShift_reg;
    logic [2:0]    byteIdx_reg;
    logic [7:0]    opcode_reg;
    logic [15:0]   addr_reg;
    logic [11:0]   page_reg;
    logic [8:0]    ptr_reg;
    logic          refused_reg;
    logic          readOn_reg;
    logic          pend_reg;
    logic          idleHigh_reg;
    logic          sawRise_reg;
    logic [6:0]    txShift_reg;
    logic [2:0]    txBit_reg;
    logic          so_reg;
    logic          soOe_reg;
    logic          standby_reg;
    logic          page264_reg;
    sfbf_busy_type busyState_reg;
    logic [23:0]   busyCnt_reg;
    logic [8:0]    copyIdx_reg;
    logic [11:0]   progPage_reg;
    logic          progBuf_reg;
    logic [7:0]    progOp_reg;

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    // Input is taken only while selected and the command stands
    wire       active   = csLow & ~refused_reg;
    wire [7:0] rxByte   = {rxShift_reg, siS};
    wire       byteDone = active & sckRise & (bitCnt_reg == 3'h7);
    wire       isBusy   = (busyState_reg != BUSY_IDLE);
    wire [8:0] pageLast = page264_reg ? `SFBF_LAST_264 : `SFBF_LAST_256;

    wire opWr    = (rxByte[7:1] == `SFBF_OP_BUF_WR);
    wire opProg  = (rxByte[7:1] == `SFBF_OP_BUF_PROG);
    wire opBufRd = (rxByte[7:1] == `SFBF_OP_BUF_RD);
    wire opErase = (rxByte == `SFBF_OP_PAGE_ERASE);
    wire opSecPr = (rxByte == `SFBF_OP_SEC_PROG);
    wire opStat  = (rxByte == `SFBF_OP_STATUS);
    wire opIdRd  = (rxByte == `SFBF_OP_ID_RD);
    wire opSize  = (rxByte[7:1] == 7'(`SFBF_OP_SIZE_256 >> 1));
    wire opKnown = opWr | opProg | opBufRd | opErase | opSecPr | opStat | opIdRd | opSize
                 | (rxByte == `SFBF_OP_PAGE_RD) | (rxByte == `SFBF_OP_SEC_RD);
    wire opNvm   = opProg | opErase | opSecPr;
    // While busy only status and the buffer other than progBuf_reg stay reachable
    wire okBusy  = opStat | ((opWr | opBufRd) & (rxByte[0] != progBuf_reg));
    wire refuse  = ~opKnown | (opNvm & wpLow) | (isBusy & ~okBusy);

    wire [23:0] fullAddr = {addr_reg, rxByte};
    wire [11:0] hdrPage  = page264_reg ? fullAddr[20:9] : fullAddr[19:8];
    wire [8:0]  hdrByte  = page264_reg ? fullAddr[8:0] : {1'b0, fullAddr[7:0]};
    wire        curSec   = (opcode_reg[7:4] == 4'h8);
    // Status and identity reads take no address; later bytes are don't-care
    wire        addressed = (opcode_reg != `SFBF_OP_STATUS) & (opcode_reg != `SFBF_OP_ID_RD);
    wire [8:0]  ptrNext  = (ptr_reg == pageLast) ? 9'h000 : ptr_reg + 9'h001;
    wire [7:0]  uidByte  = `SFBF_UID_SEED ^ {2'b00, ptr_reg[5:0]};

    // Byte source for the read phase
    wire [7:0] idByte   = (ptr_reg == 9'h000) ? `SFBF_MFR_ID :
                          (ptr_reg == 9'h001) ? `SFBF_DEV_ID : 8'h00;
    wire [7:0] secByte  = ptr_reg[6] ? uidByte : secUser[ptr_reg[5:0]];
    wire [7:0] statByte = {~isBusy, 6'h00, ~page264_reg};
    wire [7:0] curByte  = (opcode_reg == `SFBF_OP_STATUS)  ? statByte :
                          (opcode_reg == `SFBF_OP_ID_RD)   ? idByte :
                          curSec                           ? secByte :
                          (opcode_reg == `SFBF_OP_PAGE_RD) ? mainMem[pageBase(page_reg) + 21'(ptr_reg)] :
                          bufMem[opcode_reg[0]][ptr_reg];
    // In mode 3 a fall can precede the first rise; it carries no data
    wire txEn = active & readOn_reg & sckFall & (sawRise_reg | ~idleHigh_reg);

    // ------------------------------------------------------------------------
    // Serial receive and command sequencing
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rstAll | csRise | ~csLow) begin
            bitCnt_reg  <= 3'h0;
            rxShift_reg <= 7'h00;
            byteIdx_reg <= 3'h0;
            opcode_reg  <= 8'h00;
            addr_reg    <= 16'h0000;
            refused_reg <= 1'b0;
            readOn_reg  <= 1'b0;
            sawRise_reg <= 1'b0;
        end else if (active & sckRise) begin
            sawRise_reg <= 1'b1;
            bitCnt_reg  <= bitCnt_reg + 3'h1;
            rxShift_reg <= rxByte[6:0];
            if (bitCnt_reg == 3'h7) begin
                if (byteIdx_reg != 3'h4)
                    byteIdx_reg <= byteIdx_reg + 3'h1;
                if (byteIdx_reg == 3'h0) begin
                    opcode_reg  <= rxByte;
                    refused_reg <= refuse;
                    readOn_reg  <= ~refuse & (opStat | opIdRd);
                end else if (byteIdx_reg < 3'h3) begin
                    addr_reg <= fullAddr[15:0];
                end else if ((byteIdx_reg == 3'h3) & addressed) begin
                    readOn_reg <= (opcode_reg[7:1] == `SFBF_OP_BUF_RD)
                                | (opcode_reg == `SFBF_OP_PAGE_RD) | (opcode_reg == `SFBF_OP_SEC_RD);
                end
            end
        end
    end

    // Pointer, page latch, idle level and page-size setting
    always_ff @(posedge ref_clk) begin
        if (rstAll) begin
            ptr_reg      <= 9'h000;
            page_reg     <= 12'h000;
            idleHigh_reg <= 1'b0;
        end else begin
            if (csFall)
                idleHigh_reg <= pinSync_reg[1];
            if (byteDone & (byteIdx_reg == 3'h0))
                ptr_reg <= 9'h000;
            else if (byteDone & (byteIdx_reg == 3'h3) & addressed) begin
                ptr_reg  <= curSec ? {2'b00, fullAddr[6:0]} : hdrByte;
                page_reg <= hdrPage;
            end else if ((byteDone & (byteIdx_reg == 3'h4) & ~readOn_reg) | (txEn & (txBit_reg == 3'h0)))
                ptr_reg <= curSec ? {2'b00, ptr_reg[6:0] + 7'h01} : ptrNext;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            page264_reg <= `SFBF_PAGE264_RST;
        else if (byteDone & (byteIdx_reg == 3'h0) & opSize & ~isBusy)
            page264_reg <= rxByte[0];
    end

    // Data bytes into a buffer or the user half of the security area
    always_ff @(posedge ref_clk) begin
        if (byteDone & (byteIdx_reg == 3'h4)) begin
            if (opcode_reg[7:1] == `SFBF_OP_BUF_WR)
                bufMem[opcode_reg[0]][ptr_reg] <= rxByte;
            if ((opcode_reg == `SFBF_OP_SEC_PROG) & ~ptr_reg[6])
                secUser[ptr_reg[5:0]] <= rxByte;
        end
    end

    // ------------------------------------------------------------------------
    // Serial transmit
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rstAll | ~csLow) begin
            so_reg      <= 1'b0;
            txShift_reg <= 7'h00;
            txBit_reg   <= 3'h0;
            soOe_reg    <= 1'b0;
        end else begin
            soOe_reg <= 1'b1;
            if (txEn) begin
                txBit_reg <= txBit_reg + 3'h1;
                if (txBit_reg == 3'h0) begin
                    so_reg      <= curByte[7];
                    txShift_reg <= curByte[6:0];
                end else begin
                    so_reg      <= txShift_reg[6];
                    txShift_reg <= {txShift_reg[5:0], 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Self-timed program and erase engine
    // ------------------------------------------------------------------------
    // Armed when the address is complete, launched only at the select rise
    wire nvmCmd = (opcode_reg[7:1] == `SFBF_OP_BUF_PROG) | (opcode_reg == `SFBF_OP_PAGE_ERASE)
                | (opcode_reg == `SFBF_OP_SEC_PROG);

    always_ff @(posedge ref_clk) begin
        if (rstAll) begin
            pend_reg      <= 1'b0;
            busyState_reg <= BUSY_IDLE;
            busyCnt_reg   <= 24'h000000;
            copyIdx_reg   <= 9'h000;
            progPage_reg  <= 12'h000;
            progBuf_reg   <= 1'b0;
            progOp_reg    <= 8'h00;
            standby_reg   <= 1'b1;
        end else begin
            standby_reg <= ~csLow & ~isBusy;
            if (byteDone & (byteIdx_reg == 3'h3) & nvmCmd) begin
                pend_reg     <= 1'b1;
                progPage_reg <= hdrPage;
                progBuf_reg  <= opcode_reg[0];
                progOp_reg   <= opcode_reg;
            end else if (csRise)
                pend_reg <= 1'b0;
            unique case (busyState_reg)
                BUSY_IDLE: begin
                    copyIdx_reg <= 9'h000;
                    if (csRise & pend_reg) begin
                        if (progOp_reg == `SFBF_OP_SEC_PROG) begin
                            busyState_reg <= BUSY_WAIT;
                            busyCnt_reg   <= 24'(PROG_CYCLES);
                        end else if (progOp_reg == `SFBF_OP_PAGE_ERASE)
                            busyState_reg <= BUSY_ERASE;
                        else
                            busyState_reg <= BUSY_COPY;
                    end
                end
                BUSY_COPY, BUSY_ERASE: begin
                    copyIdx_reg <= copyIdx_reg + 9'h001;
                    if (copyIdx_reg == pageLast) begin
                        busyState_reg <= BUSY_WAIT;
                        busyCnt_reg   <= (busyState_reg == BUSY_COPY) ? 24'(PROG_CYCLES) : 24'(ERASE_CYCLES);
                    end
                end
                BUSY_WAIT: begin
                    busyCnt_reg <= busyCnt_reg - 24'h000001;
                    if (busyCnt_reg <= 24'h000001)
                        busyState_reg <= BUSY_IDLE;
                end
            endcase
        end
    end

    // Array writes during the copy or erase sweep
    always_ff @(posedge ref_clk) begin
        if (busyState_reg == BUSY_COPY)
            mainMem[pageBase(progPage_reg) + 21'(copyIdx_reg)] <= bufMem[progBuf_reg][copyIdx_reg];
        else if (busyState_reg == BUSY_ERASE)
            mainMem[pageBase(progPage_reg) + 21'(copyIdx_reg)] <= 8'hFF;
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign soOut   = so_reg;
    assign soOe    = soOe_reg;
    assign standby = standby_reg;
    assign busy    = (busyState_reg != BUSY_IDLE);
endmodule

//--- tb/sfbf_frontend_props.sv
/*
 * Checker for the serial flash front end: timing relations at its pins.
 * Assumes it is bound to sfbf_frontend and that the serial clock half period is at least 4 ref_clk.
 */
`timescale 1ns/1ps

module sfbf_frontend_props #(
    parameter int PROG_CYCLES  = 10000,
    parameter int ERASE_CYCLES = 10000
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic csN,
    input wire logic sck,
    input wire logic si,
    input wire logic wpN,
    input wire logic rstN,
    input wire logic soOut,
    input wire logic soOe,
    input wire logic standby,
    input wire logic busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------------------
    // Busy length counter
    // ------------------------------------------------------------------------
    localparam int BusyMax = 264 + ((PROG_CYCLES > ERASE_CYCLES) ? PROG_CYCLES : ERASE_CYCLES) + 8;
    int busyCnt;
    // Counter instead of a long repetition, which the tools would unroll
    always_ff @(posedge ref_clk) begin
        busyCnt <= (sys_rst || !busy) ? 0 : busyCnt + 1;
    end
    property p_desel_float; csN[*6] |-> !soOe; endproperty
    property p_sel_drive; $fell(csN) ##0 (!csN)[*7] |-> soOe; endproperty
    property p_standby_idle; csN[*6] ##0 (!busy)[*3] |-> standby; endproperty
    property p_busy_standby; busy && $past(busy) |-> !standby; endproperty
    property p_so_fall; (!csN)[*4] ##0 (soOe && $past(soOe) && $changed(soOut)) |-> !$past(sck); endproperty
    property p_busy_min; $rose(busy) |-> busy[*8]; endproperty
    property p_busy_max; busyCnt <= BusyMax; endproperty
    property p_reset_abort; (!rstN)[*5] |-> !busy; endproperty
    property p_wp_block; $rose(busy) |-> $past(wpN, 6); endproperty
    property p_start_frame; $rose(busy) |-> !$past(csN, 8); endproperty
    a_desel_float: assert property (p_desel_float) else $error("output enabled while deselected");
    a_sel_drive: assert property (p_sel_drive) else $error("output not enabled in frame");
    a_standby_idle: assert property (p_standby_idle) else $error("standby missing when idle");
    a_busy_standby: assert property (p_busy_standby) else $error("standby during busy");
    a_so_fall: assert property (p_so_fall) else $error("output changed off a falling edge");
    a_busy_min: assert property (p_busy_min) else $error("busy too short");
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    a_reset_abort: assert property (p_reset_abort) else $error("busy kept in reset");
    a_wp_block: assert property (p_wp_block) else $error("busy despite write protect");
    a_start_frame: assert property (p_start_frame) else $error("busy without a frame");
    c_busy: cover property ($rose(busy));
    c_mode3: cover property ($fell(csN) && sck);
    c_abort: cover property (!rstN && busy);
endmodule

bind sfbf_frontend sfbf_frontend_props #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) i_sfbf_frontend_props (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .csN(csN), .sck(sck), .si(si), .wpN(wpN), .rstN(rstN),
    .soOut(soOut), .soOe(soOe), .standby(standby), .busy(busy));

//--- tb/sfbf_host_model.sv
/*
 * Host model: drives select, serial clock and serial input, samples serial out.
 * Assumes the caller picks mode3 before a frame; half bit is 4 ref_clk (800 ns period).
 */
`timescale 1ns/1ps

module sfbf_host_model (
    input  wire logic ref_clk,
    output logic      csN,
    output logic      sck,
    output logic      si,
    input  wire logic soOut,
    input  wire logic soOe
);
    // ------------------------------------------------------------------------
    // Serial line and frame tasks
    // ------------------------------------------------------------------------
    bit   mode3;
    logic lastSo;
    logic soLine;
    // A floating line toggles every ref_clk, starting from the inverse of the last driven bit
    assign soLine = soOe ? soOut : ~lastSo;
    always @(posedge ref_clk) lastSo <= soLine;
    initial begin
        csN = 1'b1; sck = 1'b0; si = 1'b0; mode3 = 1'b0;
    end
    task automatic wt(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic sel();
        sck = mode3;
        wt(4);
        csN = 1'b0;
        wt(4);
    endtask
    // Data changes with the fall, so it is settled long before the rise
    task automatic xb(input logic [7:0] d, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = d[i];
            wt(4);
            q[i] = soLine;
            sck = 1'b1;
            wt(4);
        end
    endtask
    task automatic desel();
        if (!mode3) begin
            sck = 1'b0;
            wt(4);
        end
        csN = 1'b1;
        si = ~si;
        wt(8);
    endtask
    task automatic wiggle(int n);
        repeat (n) begin
            sck = ~sck;
            si = ~si;
            wt(4);
        end
        sck = mode3;
    endtask
endmodule

//--- tb/sfbf_frontend_tb.sv
/*
 * Self-checking bench of the serial flash front end.
 * Assumes the host model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
`include "sfbf_defines.svh"

module sfbf_frontend_tb;
    import sfbf_pkg::*;
    // ------------------------------------------------------------------------
    // Set-up
    // ------------------------------------------------------------------------
    localparam int ProgCycles = 2000; // Long enough to fit buffer traffic inside
    typedef struct {bit m3; logic [7:0] op; logic [15:0] exp;} sfbf_row_type;
    logic ref_clk, sys_rst, csN, sck, si, wpN, rstN, soOut, soOe, standby, busy;
    logic [7:0] q1, q2;
    int failures, nChecks;
    sfbf_row_type rows [4];
    sfbf_frontend #(.PROG_CYCLES(ProgCycles), .ERASE_CYCLES(ProgCycles)) i_sfbf_frontend (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .csN(csN), .sck(sck), .si(si), .wpN(wpN),
        .rstN(rstN), .soOut(soOut), .soOe(soOe), .standby(standby), .busy(busy));
    sfbf_host_model i_sfbf_host_model (.ref_clk(ref_clk), .csN(csN), .sck(sck), .si(si),
        .soOut(soOut), .soOe(soOe));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        nChecks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wait_busy(logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 5000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 5000) begin
            failures++;
            $display("wrong value busy wait expected %b seen timeout", lvl);
            give_verdict();
        end
    endtask
    task automatic cmd(logic [7:0] op, logic [23:0] a);
        logic [7:0] q;
        i_sfbf_host_model.sel();
        i_sfbf_host_model.xb(op, q);
        for (int i = 2; i >= 0; i--) i_sfbf_host_model.xb(a[i*8 +: 8], q);
    endtask
    task automatic rd2(string name, logic [15:0] exp);
        i_sfbf_host_model.xb(8'h00, q1);
        i_sfbf_host_model.xb(8'h00, q2);
        i_sfbf_host_model.desel();
        chk(name, exp, {q1, q2});
    endtask
    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1; wpN = 1'b1; rstN = 1'b1; failures = 0; nChecks = 0;
        rows[0] = '{1'b0, `SFBF_OP_ID_RD, {`SFBF_MFR_ID, `SFBF_DEV_ID}};
        rows[1] = '{1'b1, `SFBF_OP_ID_RD, {`SFBF_MFR_ID, `SFBF_DEV_ID}};
        rows[2] = '{1'b0, `SFBF_OP_STATUS, 16'h8080};
        rows[3] = '{1'b1, `SFBF_OP_STATUS, 16'h8080};
        repeat (10) @(negedge ref_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("standby", 16'h1, {15'h0, standby});
        // Read commands in both clock modes, one row each
        foreach (rows[i]) begin
            i_sfbf_host_model.mode3 = rows[i].m3;
            i_sfbf_host_model.sel();
            i_sfbf_host_model.xb(rows[i].op, q1);
            rd2("row", rows[i].exp);
        end
        i_sfbf_host_model.mode3 = 1'b0;
        // Pin activity while deselected must leave nothing behind
        i_sfbf_host_model.wiggle(16);
        chk("soOe", 16'h0, {15'h0, soOe});
        // Read cut short, then a fresh opcode must decode from bit 0
        i_sfbf_host_model.sel();
        i_sfbf_host_model.xb(`SFBF_OP_ID_RD, q1);
        i_sfbf_host_model.xb(8'h00, q1);
        i_sfbf_host_model.xb(8'h00, q1);
        i_sfbf_host_model.desel();
        i_sfbf_host_model.sel();
        i_sfbf_host_model.xb(`SFBF_OP_ID_RD, q1);
        rd2("id", {`SFBF_MFR_ID, `SFBF_DEV_ID});
        // Buffer 1 write across the page end wraps to byte 0
        cmd({`SFBF_OP_BUF_WR, 1'b0}, 24'h000106);
        foreach (rows[i]) i_sfbf_host_model.xb(8'hA1 + 8'h11 * i, q1);
        i_sfbf_host_model.desel();
        cmd({`SFBF_OP_BUF_RD, 1'b0}, 24'h000107);
        rd2("buf1", 16'hB2C3);
        // Program refused under write protect
        wpN = 1'b0;
        cmd({`SFBF_OP_BUF_PROG, 1'b0}, 24'h000A00);
        i_sfbf_host_model.desel();
        repeat (20) @(negedge ref_clk);
        chk("busy", 16'h0, {15'h0, busy});
        wpN = 1'b1;
        // Program page 5, fill buffer 2 meanwhile
        cmd({`SFBF_OP_BUF_PROG, 1'b0}, 24'h000A00);
        i_sfbf_host_model.desel();
        chk("busy", 16'h1, {15'h0, busy});
        chk("standby", 16'h0, {15'h0, standby});
        cmd({`SFBF_OP_BUF_WR, 1'b1}, 24'h000000);
        i_sfbf_host_model.xb(8'h5E, q1);
        i_sfbf_host_model.xb(8'h6F, q1);
        i_sfbf_host_model.desel();
        cmd({`SFBF_OP_BUF_RD, 1'b1}, 24'h000000);
        rd2("buf2", 16'h5E6F);
        chk("busy", 16'h1, {15'h0, busy});
        wait_busy(1'b0);
        repeat (4) @(negedge ref_clk);
        chk("standby", 16'h1, {15'h0, standby});
        cmd(`SFBF_OP_PAGE_RD, 24'h000B06);
        rd2("page", 16'hA1B2);
        // Reset pin in mid-program
        cmd({`SFBF_OP_BUF_PROG, 1'b0}, 24'h000A00);
        i_sfbf_host_model.desel();
        rstN = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk("busy", 16'h0, {15'h0, busy});
        rstN = 1'b1;
        repeat (5) @(negedge ref_clk);
        give_verdict();
    end
endmodule
